// >>> serial_port1_pin_mux.sv
// pin multiplexer for the six pins of serial port 1
// assumes serial core logic on core_clk_i and an external bit clock
`timescale 1ns/100ps

// Contract
// - all six pins leave reset as general-purpose inputs.
// - in general-purpose mode pin direction follows its direction register bit.
// - a set control register bit gives the pin to the serial port.
// - asynchronous mode: first control pin is the receive clock, in or out.
// - synchronous mode: first control pin is transmitter 1 output or flag 0.
// - asynchronous mode: second control pin is receiver frame sync, in or out.
// - synchronous mode: second control pin is transmitter 2 output or flag 1.
// - frame sync pin serves both directions synchronous, transmitter only async.
// - frame sync pin as output drives the internal frame sync.
// - frame sync pin as input feeds transmitter, and receiver when synchronous.
// - bit clock pin clocks both directions synchronous, transmitter async.
// - receive data pin is an input feeding the receive shift path.
// - transmit data pin drives transmit data while transmitting.
module serial_port1_pin_mux
  import serial_port1_pkg::*;
(
  // clock and reset
  input  wire logic                core_clk_i,
  input  wire logic                rst_b_i,
  // link clock, the external bit clock
  input  wire logic                link_clk_i,
  // register port
  input  wire logic [ADDR_W-1:0]   reg_addr_i,
  input  wire logic [DATA_W-1:0]   reg_wdata_i,
  input  wire logic                reg_wr_i,
  input  wire logic                reg_rd_i,
  output logic      [DATA_W-1:0]   reg_rdata_o,
  // serial port core
  input  wire serial_drive_t       sp_drive_i,
  output serial_sense_t            sp_sense_o,
  // pins
  input  wire logic [PIN_N-1:0]    pin_i,
  output logic      [PIN_N-1:0]    pin_o,
  output logic      [PIN_N-1:0]    pin_oe_o
);

  logic                rst_s1_r;
  logic                rst_core_b_r;
  logic [PIN_N-1:0]    ctrl_r;
  logic [PIN_N-1:0]    dir_r;
  logic [PIN_N-1:0]    gp_out_r;
  serial_cfg_t         cfg_r;
  logic [PIN_N-1:0]    pin_s1_r;
  logic [PIN_N-1:0]    pin_s2_r;
  logic [PIN_N-1:0]    pin_nxt;
  logic [PIN_N-1:0]    oe_nxt;
  serial_sense_t       sense_nxt;
  logic [1:0]          bit_slot;
  logic [1:0]          fs_slot;
  logic                link_toggle;
  logic                tog_s1_r;
  logic                tog_s2_r;
  logic                tog_s3_r;
  logic                rx_evt;
  logic                rx_last_bit_r;
  logic                rx_last_fs_r;
  logic [5:0]          rx_count_r;

  // ******************************************************
  // reset release through two flops
  // ******************************************************
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_s1_r     <= 1'b0;
      rst_core_b_r <= 1'b0;
    end else begin
      rst_s1_r     <= 1'b1;
      rst_core_b_r <= rst_s1_r;
    end
  end

  // ******************************************************
  // register writes
  // ******************************************************
  function automatic logic is_wr(input logic [ADDR_W-1:0] a);
    return reg_wr_i && (reg_addr_i == a);
  endfunction

  always_ff @(posedge core_clk_i or negedge rst_core_b_r) begin
    if (!rst_core_b_r) begin
      ctrl_r <= CTRL_RST;
    end else if (is_wr(ADDR_CTRL)) begin
      ctrl_r <= reg_wdata_i[PIN_N-1:0];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_core_b_r) begin
    if (!rst_core_b_r) begin
      dir_r <= DIR_RST;
    end else if (is_wr(ADDR_DIR)) begin
      dir_r <= reg_wdata_i[PIN_N-1:0];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_core_b_r) begin
    if (!rst_core_b_r) begin
      gp_out_r <= GP_OUT_RST;
    end else if (is_wr(ADDR_GP_OUT)) begin
      gp_out_r <= reg_wdata_i[PIN_N-1:0];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_core_b_r) begin
    if (!rst_core_b_r) begin
      cfg_r <= CFG_RST;
    end else if (is_wr(ADDR_CFG)) begin
      cfg_r <= reg_wdata_i[6:0];
    end
  end

  // ******************************************************
  // register reads, data in the following cycle
  // ******************************************************
  always_ff @(posedge core_clk_i or negedge rst_core_b_r) begin
    if (!rst_core_b_r) begin
      reg_rdata_o <= RD_UNMAPPED;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        ADDR_CTRL:    reg_rdata_o <= {2'h0, ctrl_r};
        ADDR_DIR:     reg_rdata_o <= {2'h0, dir_r};
        ADDR_GP_OUT:  reg_rdata_o <= {2'h0, gp_out_r};
        ADDR_GP_IN:   reg_rdata_o <= {2'h0, pin_s2_r};
        ADDR_CFG:     reg_rdata_o <= {1'b0, cfg_r};
        ADDR_RX_STAT: reg_rdata_o <= {rx_last_fs_r, rx_last_bit_r,
                                      rx_count_r};
        default:      reg_rdata_o <= RD_UNMAPPED;
      endcase
    end else begin
      reg_rdata_o <= RD_UNMAPPED;
    end
  end

  // ******************************************************
  // pin input synchronisers
  // ******************************************************
  always_ff @(posedge core_clk_i or negedge rst_core_b_r) begin
    if (!rst_core_b_r) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else begin
      pin_s1_r <= pin_i;
      pin_s2_r <= pin_s1_r;
    end
  end

  // ******************************************************
  // output role selection per pin
  // ******************************************************
  always_comb begin
    pin_nxt = gp_out_r;
    oe_nxt  = dir_r;
    if (ctrl_r[PIN_CTRL_A]) begin
      if (!cfg_r.sync_mode) begin
        oe_nxt[PIN_CTRL_A]  = cfg_r.ctrl_a_out;
        pin_nxt[PIN_CTRL_A] = sp_drive_i.rx_clk;
      end else if (cfg_r.ctrl_a_flag) begin
        oe_nxt[PIN_CTRL_A]  = cfg_r.ctrl_a_out;
        pin_nxt[PIN_CTRL_A] = sp_drive_i.flag0;
      end else begin
        oe_nxt[PIN_CTRL_A]  = 1'b1;
        pin_nxt[PIN_CTRL_A] = sp_drive_i.tx1;
      end
    end
    if (ctrl_r[PIN_CTRL_B]) begin
      if (!cfg_r.sync_mode) begin
        oe_nxt[PIN_CTRL_B]  = cfg_r.ctrl_b_out;
        pin_nxt[PIN_CTRL_B] = sp_drive_i.rx_fs;
      end else if (cfg_r.ctrl_b_flag) begin
        oe_nxt[PIN_CTRL_B]  = cfg_r.ctrl_b_out;
        pin_nxt[PIN_CTRL_B] = sp_drive_i.flag1;
      end else begin
        oe_nxt[PIN_CTRL_B]  = 1'b1;
        pin_nxt[PIN_CTRL_B] = sp_drive_i.tx2;
      end
    end
    if (ctrl_r[PIN_FS]) begin
      oe_nxt[PIN_FS]  = cfg_r.fs_out;
      pin_nxt[PIN_FS] = sp_drive_i.fs;
    end
    if (ctrl_r[PIN_CLK]) begin
      oe_nxt[PIN_CLK]  = cfg_r.clk_out;
      pin_nxt[PIN_CLK] = sp_drive_i.bit_clk;
    end
    if (ctrl_r[PIN_RXD]) begin
      oe_nxt[PIN_RXD]  = 1'b0;
      pin_nxt[PIN_RXD] = 1'b0;
    end
    if (ctrl_r[PIN_TXD]) begin
      oe_nxt[PIN_TXD]  = sp_drive_i.tx_active;
      pin_nxt[PIN_TXD] = sp_drive_i.tx_data;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_core_b_r) begin
    if (!rst_core_b_r) begin
      pin_o    <= '0;
      pin_oe_o <= '0;
    end else begin
      pin_o    <= pin_nxt;
      pin_oe_o <= oe_nxt;
    end
  end

  // ******************************************************
  // input role selection toward the serial core
  // ******************************************************
  always_comb begin
    sense_nxt = '0;
    // frame sync and bit clock pins only when inputs
    if (ctrl_r[PIN_FS] && !cfg_r.fs_out) begin
      sense_nxt.tx_fs = pin_s2_r[PIN_FS];
    end
    if (ctrl_r[PIN_CLK] && !cfg_r.clk_out) begin
      sense_nxt.tx_clk = pin_s2_r[PIN_CLK];
    end
    if (cfg_r.sync_mode) begin
      sense_nxt.rx_fs  = sense_nxt.tx_fs;
      sense_nxt.rx_clk = sense_nxt.tx_clk;
      if (ctrl_r[PIN_CTRL_A] && cfg_r.ctrl_a_flag && !cfg_r.ctrl_a_out) begin
        sense_nxt.flag0 = pin_s2_r[PIN_CTRL_A];
      end
      if (ctrl_r[PIN_CTRL_B] && cfg_r.ctrl_b_flag && !cfg_r.ctrl_b_out) begin
        sense_nxt.flag1 = pin_s2_r[PIN_CTRL_B];
      end
    end else begin
      if (ctrl_r[PIN_CTRL_A] && !cfg_r.ctrl_a_out) begin
        sense_nxt.rx_clk = pin_s2_r[PIN_CTRL_A];
      end
      if (ctrl_r[PIN_CTRL_B] && !cfg_r.ctrl_b_out) begin
        sense_nxt.rx_fs = pin_s2_r[PIN_CTRL_B];
      end
    end
    if (ctrl_r[PIN_RXD]) begin
      sense_nxt.rx_data      = pin_s2_r[PIN_RXD];
      sense_nxt.rx_bit       = rx_evt & bit_slot[tog_s2_r];
      sense_nxt.rx_bit_valid = rx_evt;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_core_b_r) begin
    if (!rst_core_b_r) begin
      sp_sense_o <= '0;
    end else begin
      sp_sense_o <= sense_nxt;
    end
  end

  // ******************************************************
  // receive capture on the link clock
  // ******************************************************
  serial_link_capture u_capture (
    .link_clk_i (link_clk_i),
    .rst_b_i    (rst_core_b_r),
    .rx_pin_i   (pin_i[PIN_RXD]),
    .fs_pin_i   (pin_i[PIN_FS]),
    .bit_slot_o (bit_slot),
    .fs_slot_o  (fs_slot),
    .toggle_o   (link_toggle)
  );

  // toggle crossing; slot stays stable two link edges
  always_ff @(posedge core_clk_i or negedge rst_core_b_r) begin
    if (!rst_core_b_r) begin
      tog_s1_r <= 1'b0;
      tog_s2_r <= 1'b0;
      tog_s3_r <= 1'b0;
    end else begin
      tog_s1_r <= link_toggle;
      tog_s2_r <= tog_s1_r;
      tog_s3_r <= tog_s2_r;
    end
  end

  assign rx_evt = tog_s2_r ^ tog_s3_r;
  always_ff @(posedge core_clk_i or negedge rst_core_b_r) begin
    if (!rst_core_b_r) begin
      rx_last_bit_r <= 1'b0;
      rx_last_fs_r  <= 1'b0;
      rx_count_r    <= 6'h00;
    end else if (rx_evt && ctrl_r[PIN_RXD]) begin
      rx_last_bit_r <= bit_slot[tog_s2_r];
      rx_last_fs_r  <= fs_slot[tog_s2_r];
      rx_count_r    <= rx_count_r + 6'h01;
    end
  end

  // ******************************************************
  // checks
  // ******************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_core_b_r);
  sequence s_async_a;
    ctrl_r[PIN_CTRL_A] && !cfg_r.sync_mode && cfg_r.ctrl_a_out;
  endsequence
  sequence s_sync_a_tx;
    ctrl_r[PIN_CTRL_A] && cfg_r.sync_mode && !cfg_r.ctrl_a_flag;
  endsequence
  property p_reset_input;
    $rose(rst_core_b_r) |-> (pin_oe_o == '0) && (ctrl_r == '0);
  endproperty
  a_reset_input: assert property (p_reset_input)
    else $error("pins not inputs after reset");
  property p_gpio_dir;
    (ctrl_r == '0) |=> (pin_oe_o == $past(dir_r));
  endproperty
  a_gpio_dir: assert property (p_gpio_dir)
    else $error("gpio direction mismatch");
  property p_ctrl_write;
    (reg_wr_i && (reg_addr_i == ADDR_CTRL))
      |=> (ctrl_r == $past(reg_wdata_i[PIN_N-1:0]));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("control write lost");
  property p_async_rx_clk;
    s_async_a |=> pin_oe_o[PIN_CTRL_A]
                  && (pin_o[PIN_CTRL_A] == $past(sp_drive_i.rx_clk));
  endproperty
  a_async_rx_clk: assert property (p_async_rx_clk)
    else $error("receive clock not driven");
  property p_sync_tx1;
    s_sync_a_tx |=> pin_oe_o[PIN_CTRL_A]
                    && (pin_o[PIN_CTRL_A] == $past(sp_drive_i.tx1));
  endproperty
  a_sync_tx1: assert property (p_sync_tx1)
    else $error("transmitter 1 not driven");
  property p_sync_tx2;
    (ctrl_r[PIN_CTRL_B] && cfg_r.sync_mode && !cfg_r.ctrl_b_flag)
      |=> pin_oe_o[PIN_CTRL_B]
          && (pin_o[PIN_CTRL_B] == $past(sp_drive_i.tx2));
  endproperty
  a_sync_tx2: assert property (p_sync_tx2)
    else $error("transmitter 2 not driven");
  property p_fs_out;
    (ctrl_r[PIN_FS] && cfg_r.fs_out)
      |=> pin_oe_o[PIN_FS] && (pin_o[PIN_FS] == $past(sp_drive_i.fs));
  endproperty
  a_fs_out: assert property (p_fs_out)
    else $error("frame sync not driven");
  property p_fs_in;
    (ctrl_r[PIN_FS] && !cfg_r.fs_out && cfg_r.sync_mode)
      |=> (sp_sense_o.tx_fs == $past(pin_s2_r[PIN_FS]))
          && (sp_sense_o.rx_fs == sp_sense_o.tx_fs);
  endproperty
  a_fs_in: assert property (p_fs_in)
    else $error("frame sync input not routed");
  property p_rxd_input;
    ctrl_r[PIN_RXD] |=> !pin_oe_o[PIN_RXD];
  endproperty
  a_rxd_input: assert property (p_rxd_input)
    else $error("receive pin driven");
  property p_txd_drive;
    (ctrl_r[PIN_TXD] && sp_drive_i.tx_active)
      |=> pin_oe_o[PIN_TXD] && (pin_o[PIN_TXD] == $past(sp_drive_i.tx_data));
  endproperty
  a_txd_drive: assert property (p_txd_drive)
    else $error("transmit data not driven");
  property p_clk_dir;
    (ctrl_r[PIN_CLK] && !cfg_r.clk_out) |=> !pin_oe_o[PIN_CLK];
  endproperty
  a_clk_dir: assert property (p_clk_dir)
    else $error("bit clock pin direction ignores config");
endmodule

// >>> serial_port1_pkg.sv
// shared constants and carriers for the serial port 1 pin multiplexer
// assumes a core clock of 100 MHz and a plain strobe register port
package serial_port1_pkg;

  // ******************************************************
  // register map, byte wide data
  // ******************************************************
  localparam int          ADDR_W       = 3;
  localparam int          DATA_W       = 8;
  localparam int          PIN_N        = 6;
  localparam logic [2:0]  ADDR_CTRL    = 3'h0;  // port_control_reg
  localparam logic [2:0]  ADDR_DIR     = 3'h1;  // port_direction_reg
  localparam logic [2:0]  ADDR_GP_OUT  = 3'h2;
  localparam logic [2:0]  ADDR_GP_IN   = 3'h3;
  localparam logic [2:0]  ADDR_CFG     = 3'h4;
  localparam logic [2:0]  ADDR_RX_STAT = 3'h5;
  localparam logic [7:0]  RD_UNMAPPED  = 8'h00;

  // ******************************************************
  // reset values
  // ******************************************************
  localparam logic [5:0]  CTRL_RST     = 6'h00;
  localparam logic [5:0]  DIR_RST      = 6'h00;
  localparam logic [5:0]  GP_OUT_RST   = 6'h00;
  localparam logic [6:0]  CFG_RST      = 7'h00;

  // ******************************************************
  // pin positions
  // ******************************************************
  localparam int          PIN_CTRL_A   = 0;
  localparam int          PIN_CTRL_B   = 1;
  localparam int          PIN_FS       = 2;
  localparam int          PIN_CLK      = 3;
  localparam int          PIN_RXD      = 4;
  localparam int          PIN_TXD      = 5;

  // ******************************************************
  // serial role configuration, high bit first
  // ******************************************************
  typedef struct packed {
    logic ctrl_b_flag;
    logic ctrl_a_flag;
    logic clk_out;
    logic fs_out;
    logic ctrl_b_out;
    logic ctrl_a_out;
    logic sync_mode;
  } serial_cfg_t;

  // from the serial port core to the pins
  typedef struct packed {
    logic tx1;
    logic tx2;
    logic flag0;
    logic flag1;
    logic rx_clk;
    logic rx_fs;
    logic fs;
    logic bit_clk;
    logic tx_data;
    logic tx_active;
  } serial_drive_t;

  // from the pins to the serial port core
  typedef struct packed {
    logic rx_clk;
    logic rx_fs;
    logic tx_fs;
    logic tx_clk;
    logic rx_data;
    logic flag0;
    logic flag1;
    logic rx_bit;
    logic rx_bit_valid;
  } serial_sense_t;

endpackage

// >>> serial_link_capture.sv
// link side capture of receive data and frame sync
// assumes link_clk_i is the serial bit clock seen at the clock pin
`timescale 1ns/100ps
module serial_link_capture
  import serial_port1_pkg::*;
(
  // link clock and reset
  input  wire logic       link_clk_i,
  input  wire logic       rst_b_i,
  // pins sampled on the link clock
  input  wire logic       rx_pin_i,
  input  wire logic       fs_pin_i,
  // two slot holding store, read by the core domain
  output logic      [1:0] bit_slot_o,
  output logic      [1:0] fs_slot_o,
  output logic            toggle_o
);

  // ******************************************************
  // capture; a slot is rewritten only two edges later
  // ******************************************************
  // bit clock stands still between frames, so no link side
  // release flops: they would eat the first two bits; the
  // bit clock must be idle while the core reset is released
  always_ff @(posedge link_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bit_slot_o <= 2'h0;
      fs_slot_o  <= 2'h0;
      toggle_o   <= 1'b0;
    end else begin
      bit_slot_o[~toggle_o] <= rx_pin_i;
      fs_slot_o[~toggle_o]  <= fs_pin_i;
      toggle_o              <= ~toggle_o;
    end
  end

endmodule

// >>> serial_codec_model.sv
// far side codec model for the serial port 1 pins
// assumes the bench resolves every pin from device drive and val_o
`timescale 1ns/100ps
module serial_codec_model (
  // control from the bench
  input  wire logic       run_i,
  input  wire logic [7:0] bits_i,
  input  wire logic [5:0] lvl_i,
  // codec drive, used wherever the device leaves a pin as input
  output logic      [5:0] val_o,
  output logic            busy_o
);
  logic clk_r  = 1'b0;
  logic fs_r   = 1'b0;
  logic dat_r  = 1'b0;
  logic busy_r = 1'b0;

  assign busy_o = busy_r;

  // ******************************************************
  // static levels outside frames, clock stands still
  // ******************************************************
  assign val_o = busy_o ? {lvl_i[5], dat_r, clk_r, fs_r, lvl_i[1:0]}
                        : lvl_i;

  // ******************************************************
  // one frame of eight bits, msb first
  // ******************************************************
  always @(posedge run_i) begin
    busy_r = 1'b1;
    #3.3;
    for (int i = 7; i >= 0; i--) begin
      dat_r = bits_i[i];
      fs_r  = (i == 7);
      #15 clk_r = 1'b1;
      #15 clk_r = 1'b0;
    end
    busy_r = 1'b0;
  end
endmodule

// >>> serial_port1_pin_mux_tb.sv
// self checking bench for the serial port 1 pin multiplexer
// assumes the codec model drives every pin the device leaves as input
`timescale 1ns/100ps
module serial_port1_pin_mux_tb
  import serial_port1_pkg::*;
;
  logic                core_clk;
  logic                rst_b;
  logic [ADDR_W-1:0]   reg_addr;
  logic [DATA_W-1:0]   reg_wdata;
  logic                reg_wr;
  logic                reg_rd;
  logic [DATA_W-1:0]   reg_rdata;
  serial_drive_t       drv;
  serial_sense_t       sense;
  logic [PIN_N-1:0]    pin_w;
  logic [PIN_N-1:0]    pin_o;
  logic [PIN_N-1:0]    pin_oe;
  logic [PIN_N-1:0]    ext_val;
  logic [PIN_N-1:0]    lvl;
  logic [7:0]          bits;
  logic                run;
  logic                busy;
  logic [31:0]         seed;
  logic [7:0]          rd_q[$];
  logic                rx_q[$];
  logic                rd_pend;
  int                  n_errors;
  int                  checks;

  serial_port1_pin_mux uut (
    .core_clk_i(core_clk), .rst_b_i(rst_b), .link_clk_i(pin_w[PIN_CLK]),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .sp_drive_i(drv),
    .sp_sense_o(sense), .pin_i(pin_w), .pin_o(pin_o), .pin_oe_o(pin_oe));

  serial_codec_model codec (
    .run_i(run), .bits_i(bits), .lvl_i(lvl), .val_o(ext_val),
    .busy_o(busy));

  always_comb
    for (int k = 0; k < PIN_N; k++)
      pin_w[k] = pin_oe[k] ? pin_o[k] : ext_val[k];

  always #5 core_clk = ~core_clk;

  // ******************************************************
  // helpers
  // ******************************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  function automatic logic [11:0] exp_pins(
      input logic [5:0] ct, input logic [5:0] dr, input logic [5:0] go,
      input serial_cfg_t c, input serial_drive_t d);
    logic [5:0] oe;
    logic [5:0] o;
    oe = dr & ~ct;
    o  = go;
    if (ct[0]) begin
      oe[0] = (c.sync_mode & ~c.ctrl_a_flag) | c.ctrl_a_out;
      o[0]  = c.sync_mode ? (c.ctrl_a_flag ? d.flag0 : d.tx1) : d.rx_clk;
    end
    if (ct[1]) begin
      oe[1] = (c.sync_mode & ~c.ctrl_b_flag) | c.ctrl_b_out;
      o[1]  = c.sync_mode ? (c.ctrl_b_flag ? d.flag1 : d.tx2) : d.rx_fs;
    end
    if (ct[2]) begin
      oe[2] = c.fs_out;
      o[2]  = d.fs;
    end
    if (ct[3]) begin
      oe[3] = c.clk_out;
      o[3]  = d.bit_clk;
    end
    if (ct[4])
      oe[4] = 1'b0;
    if (ct[5]) begin
      oe[5] = d.tx_active;
      o[5]  = d.tx_data;
    end
    return {oe, o & oe};
  endfunction

  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic reg_wr_t(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic reg_rd_t(input logic [2:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    rd_q.push_back(e);
    @(posedge core_clk);
    reg_rd   <= 1'b0;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // ******************************************************
  // output watcher
  // ******************************************************
  always @(posedge core_clk) begin
    if (rd_pend)
      chk("reg_rdata", reg_rdata, rd_q.pop_front());
    rd_pend = reg_rd;
    if (sense.rx_bit_valid === 1'b1 && rx_q.size() > 0)
      chk("rx_bit", 8'(sense.rx_bit), 8'(rx_q.pop_front()));
  end

  // ******************************************************
  // main sequence
  // ******************************************************
  initial begin
    logic [11:0] e;
    logic [5:0]  ct;
    logic [5:0]  dr;
    logic [5:0]  go;
    logic [6:0]  cf;
    core_clk  = 1'b0;
    rst_b     = 1'b0;
    reg_addr  = '0;
    reg_wdata = '0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    drv       = '0;
    lvl       = '0;
    bits      = '0;
    run       = 1'b0;
    rd_pend   = 1'b0;
    n_errors  = 0;
    checks    = 0;
    seed      = 32'h1186_c12a;
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    settle(3);
    chk("pin_oe", 8'(pin_oe), 8'h00);
    reg_rd_t(ADDR_CTRL, 8'h00);
    reg_rd_t(ADDR_DIR, 8'h00);
    reg_rd_t(ADDR_GP_OUT, 8'h00);
    reg_rd_t(ADDR_CFG, 8'h00);
    reg_rd_t(ADDR_GP_IN, 8'h00);
    reg_rd_t(ADDR_RX_STAT, 8'h00);
    reg_rd_t(3'h6, RD_UNMAPPED);
    reg_rd_t(3'h7, RD_UNMAPPED);
    settle(2);
    $display("test reset done");

    for (int i = 0; i < 32; i++) begin
      seed = xs(seed);
      {cf, go, dr, ct} = seed[24:0];
      reg_wr_t(ADDR_CTRL, {seed[31:30], ct});
      reg_wr_t(ADDR_DIR, {2'b00, dr});
      reg_wr_t(ADDR_GP_OUT, {2'b00, go});
      reg_wr_t(ADDR_CFG, {1'b0, cf});
      seed = xs(seed);
      drv <= seed[9:0];
      reg_rd_t(ADDR_CTRL, {2'b00, ct});
      settle(3);
      e = exp_pins(ct, dr, go, cf, drv);
      chk("pin_oe", 8'(pin_oe), 8'(e[11:6]));
      chk("pin_o", 8'(pin_o & pin_oe), 8'(e[5:0]));
    end
    $display("test pin roles done");

    reg_wr_t(ADDR_CTRL, 8'h3F);
    @(posedge core_clk);
    drv <= '0;
    for (int m = 0; m < 8; m++) begin
      seed = xs(seed);
      reg_wr_t(ADDR_CFG, {1'b0, m[1], m[1], 4'h0, m[0]});
      lvl <= seed[5:0];
      settle(6);
      chk("tx_fs", 8'(sense.tx_fs), 8'(lvl[2]));
      chk("rx_fs", 8'(sense.rx_fs), 8'(m[0] ? lvl[2] : lvl[1]));
      chk("tx_clk", 8'(sense.tx_clk), 8'(lvl[3]));
      chk("rx_clk", 8'(sense.rx_clk), 8'(m[0] ? lvl[3] : lvl[0]));
      chk("rx_data", 8'(sense.rx_data), 8'(lvl[4]));
      chk("flag0", 8'(sense.flag0), 8'(m[0] & m[1] & lvl[0]));
      chk("flag1", 8'(sense.flag1), 8'(m[0] & m[1] & lvl[1]));
    end
    @(posedge core_clk);
    lvl <= '0;
    settle(8);
    $display("test sense done");

    @(posedge core_clk);
    rst_b <= 1'b0;
    settle(4);
    chk("pin_oe", 8'(pin_oe), 8'h00);
    @(posedge core_clk);
    rst_b <= 1'b1;
    settle(3);
    reg_rd_t(ADDR_CTRL, 8'h00);
    reg_wr_t(ADDR_CTRL, 8'h3F);
    reg_wr_t(ADDR_CFG, 8'h01);
    for (int f = 0; f < 2; f++) begin
      seed = xs(seed);
      @(posedge core_clk);
      bits <= seed[7:0];
      for (int b = 7; b >= 0; b--)
        rx_q.push_back(seed[b]);
      run <= 1'b1;
      @(posedge core_clk);
      run <= 1'b0;
      for (int t = 0; t < 400 && (busy || rx_q.size() > 0); t++)
        @(posedge core_clk);
      if (rx_q.size() > 0) begin
        n_errors++;
        $display("Error rx_frame expected 8 bits seen fewer");
        complete_run();
      end
    end
    reg_rd_t(ADDR_RX_STAT, {1'b0, seed[0], 6'h10});
    $display("test link receive done");
    settle(4);
    complete_run();
  end
endmodule
